// File: common/sssir_defines.vh
// Register map, field positions and reset values of the serial status block
`ifndef SSSIR_DEFINES_VH
`define SSSIR_DEFINES_VH

// Byte addresses on the register bus
`define SSSIR_ADR_W        8
`define SSSIR_OFF_RXHOLD   8'h20
`define SSSIR_OFF_TXHOLD   8'h24
`define SSSIR_OFF_RXSYNC   8'h30
`define SSSIR_OFF_TXSYNC   8'h34
`define SSSIR_OFF_CMPA     8'h38
`define SSSIR_OFF_CMPB     8'h3C
`define SSSIR_OFF_STATUS   8'h40
`define SSSIR_OFF_IRQSET   8'h44
`define SSSIR_OFF_IRQCLR   8'h48
`define SSSIR_OFF_IRQMASK  8'h4C
`define SSSIR_OFF_CONFIG   8'h50

// Status, enable, disable and mask layout
`define SSSIR_NFLAG        12
`define SSSIR_B_TX_READY_FLAG      0
`define SSSIR_B_TX_EMPTY_FLAG    1
`define SSSIR_B_TXEND      2
`define SSSIR_B_TX_BUFFERS_EMPTY_FLAG     3
`define SSSIR_B_RX_READY_FLAG      4
`define SSSIR_B_RX_OVERRUN_FLAG      5
`define SSSIR_B_RXEND      6
`define SSSIR_B_RX_BUFFERS_FULL_FLAG     7
`define SSSIR_B_CMPA       8
`define SSSIR_B_CMPB       9
`define SSSIR_B_TX_SYNC_FLAG      10
`define SSSIR_B_RX_SYNC_FLAG      11
`define SSSIR_B_TX_ENABLED_STATUS       16
`define SSSIR_B_RX_ENABLED_STATUS       17

// Config register fields
`define SSSIR_CF_LEN_LO    0
`define SSSIR_CF_LEN_HI    4
`define SSSIR_CF_EDGE      8
`define SSSIR_CF_FRAME_SYNC_DATA_EN     9
`define SSSIR_CF_RST       10'h01F
`define SSSIR_CF_W         10

// Edge select codes
`define SSSIR_EDGE_RISE    1'h0
`define SSSIR_EDGE_FALL    1'h1

`define SSSIR_SYNC_W       16
`define SSSIR_SYNC_CNT_W   4
`define SSSIR_WORD_RST     32'h0000_0000
`define SSSIR_HALF_RST     16'h0000
`define SSSIR_MASK_RST     12'h000

`endif

// File: design/sssir_top.v
// Status, interrupt and holding registers of a synchronous serial controller
//
// Functional notes
// - Edge select 0 makes rising frame sync raise tx sync; 1 falling.
// - Receive and transmit words are right-aligned whatever word length is set.
// - Transmit ready is low while a word waits in holding, high when empty.
// - Transmit empty rises only after last word loaded and fully shifted out.
// - Transmit DMA end sets at count zero; cleared by counter writes.
// - Transmit buffers empty is high exactly when both transmit counts are zero.
// - Receive ready sets when a word lands; low while holding is empty.
// - Overrun sets when a word lands unread; held until status read.
// - Receive DMA end sets at count zero; cleared by counter writes.
// - Receive buffers full is high exactly when both receive counts are zero.
// - Compare flags set on match, cleared by status read.
// - Sync flags set on frame sync events, cleared by status read.
// - Status, enable, disable, mask share bits 0-11; 16-17 enable status.
// - Writing one to enable register sets mask bit; zero no effect.
// - Writing one to disable register clears mask bit; zero no effect.
// - Mask register reads one per enabled source, zero per disabled.
// - With sync data enabled, sync holding shifts out during frame sync.
`include "sssir_defines.vh"

module sssir_top (
   input  wire                    CLK,
   input  wire                    RST,
   input  wire                    WB_CYC_I,
   input  wire                    WB_STB_I,
   input  wire                    WB_WE_I,
   input  wire [`SSSIR_ADR_W-1:0] WB_ADR_I,
   input  wire [3:0]              WB_SEL_I,
   input  wire [31:0]             WB_DAT_I,
   output wire [31:0]             WB_DAT_O,
   output wire                    WB_ACK_O,
   output wire                    IRQ,
   output wire [31:0]             TX_WORD,
   output wire                    TX_WORD_VALID,
   input  wire                    TX_SHIFT_LOAD,
   input  wire                    TX_SHIFT_BUSY,
   input  wire [31:0]             RX_WORD_IN,
   input  wire                    RX_WORD_LOAD,
   input  wire [15:0]             RX_SYNC_IN,
   input  wire                    RX_SYNC_LOAD,
   input  wire                    RX_SYNC_EVT,
   input  wire                    TX_CNT_ZERO,
   input  wire                    TX_NCNT_ZERO,
   input  wire                    TX_CNT_WR,
   input  wire                    RX_CNT_ZERO,
   input  wire                    RX_NCNT_ZERO,
   input  wire                    RX_CNT_WR,
   input  wire                    TX_EN_STAT,
   input  wire                    RX_EN_STAT,
   input  wire                    TF_PIN,
   input  wire                    TK_PIN,
   output wire                    TD_SYNC_BIT,
   output wire                    TD_SYNC_OE
);

   // Bus slave
   reg                       ack_r;
   reg  [31:0]               dat_r;
   reg  [31:0]               dat_nxt;
   wire                      acc = WB_CYC_I & WB_STB_I & ~ack_r;
   wire                      wr = acc & WB_WE_I;
   wire                      rd = acc & ~WB_WE_I;
   wire                      hit_rxhold = (WB_ADR_I == `SSSIR_OFF_RXHOLD);
   wire                      hit_txhold = (WB_ADR_I == `SSSIR_OFF_TXHOLD);
   wire                      hit_txsync = (WB_ADR_I == `SSSIR_OFF_TXSYNC);
   wire                      hit_cmpa = (WB_ADR_I == `SSSIR_OFF_CMPA);
   wire                      hit_cmpb = (WB_ADR_I == `SSSIR_OFF_CMPB);
   wire                      hit_status = (WB_ADR_I == `SSSIR_OFF_STATUS);
   wire                      hit_irqset = (WB_ADR_I == `SSSIR_OFF_IRQSET);
   wire                      hit_irqclr = (WB_ADR_I == `SSSIR_OFF_IRQCLR);
   wire                      hit_config = (WB_ADR_I == `SSSIR_OFF_CONFIG);
   wire                      sr_read = rd & hit_status;

   // Byte-lane merge for writable registers
   wire [31:0]               lane = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                                     {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

   // Storage
   reg  [31:0]               rx_word_r;
   reg  [31:0]               tx_word_r;
   reg  [15:0]               rx_sync_word_r;
   reg  [15:0]               tx_sync_word_r;
   reg  [15:0]               cmp_a_r;
   reg  [15:0]               cmp_b_r;
   reg  [`SSSIR_CF_W-1:0]    cfg_r;
   reg  [`SSSIR_NFLAG-1:0]   mask_r;

   // Flags
   reg                       tx_hold_r;
   reg                       tx_empty_flag_r;
   reg                       tx_dma_end_flag_r;
   reg                       tx_buffers_empty_flag_r;
   reg                       rx_ready_flag_r;
   reg                       rx_overrun_flag_r;
   reg                       rx_dma_end_flag_r;
   reg                       rx_buffers_full_flag_r;
   reg                       compare_a_flag_r;
   reg                       compare_b_flag_r;
   reg                       tx_sync_flag_r;
   reg                       rx_sync_flag_r;
   reg                       tx_cnt_zero_d_r;
   reg                       rx_cnt_zero_d_r;
   reg                       irq_r;

   wire [4:0]                word_length = cfg_r[`SSSIR_CF_LEN_HI:`SSSIR_CF_LEN_LO];
   wire                      frame_sync_edge_sel = cfg_r[`SSSIR_CF_EDGE];
   wire                      frame_sync_data_en = cfg_r[`SSSIR_CF_FRAME_SYNC_DATA_EN];

   // Keeps bits 0..word_length, so a short word stays right-aligned
   wire [31:0]               len_mask = {32{1'b1}} >> (5'h1F - word_length);

   wire [`SSSIR_NFLAG-1:0]   flags;
   assign flags[`SSSIR_B_TX_READY_FLAG]   = ~tx_hold_r;
   assign flags[`SSSIR_B_TX_EMPTY_FLAG] = tx_empty_flag_r;
   assign flags[`SSSIR_B_TXEND]   = tx_dma_end_flag_r;
   assign flags[`SSSIR_B_TX_BUFFERS_EMPTY_FLAG]  = tx_buffers_empty_flag_r;
   assign flags[`SSSIR_B_RX_READY_FLAG]   = rx_ready_flag_r;
   assign flags[`SSSIR_B_RX_OVERRUN_FLAG]   = rx_overrun_flag_r;
   assign flags[`SSSIR_B_RXEND]   = rx_dma_end_flag_r;
   assign flags[`SSSIR_B_RX_BUFFERS_FULL_FLAG]  = rx_buffers_full_flag_r;
   assign flags[`SSSIR_B_CMPA]    = compare_a_flag_r;
   assign flags[`SSSIR_B_CMPB]    = compare_b_flag_r;
   assign flags[`SSSIR_B_TX_SYNC_FLAG]   = tx_sync_flag_r;
   assign flags[`SSSIR_B_RX_SYNC_FLAG]   = rx_sync_flag_r;

   // Frame sync and clock pins: three stages, a change counts on agreement
   reg  [2:0]                tf_s_r;
   reg  [2:0]                tk_s_r;
   reg                       tf_lvl_r;
   reg                       tk_lvl_r;
   wire                      tf_stable = (tf_s_r[1] == tf_s_r[2]);
   wire                      tk_stable = (tk_s_r[1] == tk_s_r[2]);
   wire                      tf_rise = tf_stable & tf_s_r[2] & ~tf_lvl_r;
   wire                      tf_fall = tf_stable & ~tf_s_r[2] & tf_lvl_r;
   wire                      tk_fall = tk_stable & ~tk_s_r[2] & tk_lvl_r;
   wire                      tx_sync_evt =
      (frame_sync_edge_sel == `SSSIR_EDGE_RISE) ? tf_rise : tf_fall;

   always @(posedge CLK)
   begin
      if (RST)
      begin
         tf_s_r   <= 3'h0;
         tk_s_r   <= 3'h0;
         tf_lvl_r <= 1'b0;
         tk_lvl_r <= 1'b0;
      end
      else
      begin
         tf_s_r <= {tf_s_r[1:0], TF_PIN};
         tk_s_r <= {tk_s_r[1:0], TK_PIN};
         if (tf_stable)
            tf_lvl_r <= tf_s_r[2];
         if (tk_stable)
            tk_lvl_r <= tk_s_r[2];
      end
   end

   // Sync data shifter, LSB first, one bit per falling link clock edge
   reg  [15:0]               sync_sh_r;
   reg                       td_bit_r;
   reg                       td_oe_r;
   always @(posedge CLK)
   begin
      if (RST)
      begin
         sync_sh_r <= `SSSIR_HALF_RST;
         td_bit_r  <= 1'b0;
         td_oe_r   <= 1'b0;
      end
      else
      begin
         if (tf_rise)
         begin
            sync_sh_r <= tx_sync_word_r;
            td_bit_r  <= tx_sync_word_r[0];
         end
         else if (tk_fall & tf_lvl_r)
         begin
            sync_sh_r <= {1'b0, sync_sh_r[15:1]};
            td_bit_r  <= sync_sh_r[1];
         end
         td_oe_r <= frame_sync_data_en & (tf_rise | (tf_lvl_r & ~tf_fall));
      end
   end

   // Read mux
   always @*
   begin
      dat_nxt = `SSSIR_WORD_RST;
      case (WB_ADR_I)
         `SSSIR_OFF_RXHOLD:  dat_nxt = rx_word_r;
         `SSSIR_OFF_RXSYNC:  dat_nxt = {16'h0000, rx_sync_word_r};
         `SSSIR_OFF_TXSYNC:  dat_nxt = {16'h0000, tx_sync_word_r};
         `SSSIR_OFF_CMPA:    dat_nxt = {16'h0000, cmp_a_r};
         `SSSIR_OFF_CMPB:    dat_nxt = {16'h0000, cmp_b_r};
         `SSSIR_OFF_STATUS:
         begin
            dat_nxt[`SSSIR_NFLAG-1:0] = flags;
            dat_nxt[`SSSIR_B_TX_ENABLED_STATUS]    = TX_EN_STAT;
            dat_nxt[`SSSIR_B_RX_ENABLED_STATUS]    = RX_EN_STAT;
         end
         `SSSIR_OFF_IRQMASK: dat_nxt[`SSSIR_NFLAG-1:0] = mask_r;
         `SSSIR_OFF_CONFIG:  dat_nxt[`SSSIR_CF_W-1:0] = cfg_r;
         default:            dat_nxt = `SSSIR_WORD_RST;
      endcase
   end

   always @(posedge CLK)
   begin
      if (RST)
      begin
         ack_r <= 1'b0;
         dat_r <= `SSSIR_WORD_RST;
      end
      else
      begin
         ack_r <= acc;
         if (rd)
            dat_r <= dat_nxt;
      end
   end

   // Writable registers and mask
   always @(posedge CLK)
   begin
      if (RST)
      begin
         tx_word_r      <= `SSSIR_WORD_RST;
         tx_sync_word_r <= `SSSIR_HALF_RST;
         cmp_a_r        <= `SSSIR_HALF_RST;
         cmp_b_r        <= `SSSIR_HALF_RST;
         cfg_r          <= `SSSIR_CF_RST;
         mask_r         <= `SSSIR_MASK_RST;
      end
      else
      begin
         if (wr & hit_txhold)
            tx_word_r <= ((tx_word_r & ~lane) | (WB_DAT_I & lane)) & len_mask;
         if (wr & hit_txsync)
            tx_sync_word_r <= (tx_sync_word_r & ~lane[15:0]) |
                              (WB_DAT_I[15:0] & lane[15:0]);
         if (wr & hit_cmpa)
            cmp_a_r <= (cmp_a_r & ~lane[15:0]) | (WB_DAT_I[15:0] & lane[15:0]);
         if (wr & hit_cmpb)
            cmp_b_r <= (cmp_b_r & ~lane[15:0]) | (WB_DAT_I[15:0] & lane[15:0]);
         if (wr & hit_config)
            cfg_r <= (cfg_r & ~lane[`SSSIR_CF_W-1:0]) |
                     (WB_DAT_I[`SSSIR_CF_W-1:0] & lane[`SSSIR_CF_W-1:0]);
         // Disable wins if both land in one cycle, which cannot happen here
         mask_r <= (mask_r |
                    ({`SSSIR_NFLAG{wr & hit_irqset}} &
                     WB_DAT_I[`SSSIR_NFLAG-1:0])) &
                   ~({`SSSIR_NFLAG{wr & hit_irqclr}} &
                     WB_DAT_I[`SSSIR_NFLAG-1:0]);
      end
   end

   // Transmit side flags
   wire                      tx_cnt_reach = TX_CNT_ZERO & ~tx_cnt_zero_d_r;
   always @(posedge CLK)
   begin
      if (RST)
      begin
         tx_hold_r               <= 1'b0;
         tx_empty_flag_r         <= 1'b1;
         tx_dma_end_flag_r       <= 1'b0;
         tx_buffers_empty_flag_r <= 1'b0;
         tx_cnt_zero_d_r         <= 1'b0;
      end
      else
      begin
         // A write overrides a simultaneous load: the new word is held
         if (wr & hit_txhold)
            tx_hold_r <= 1'b1;
         else if (TX_SHIFT_LOAD)
            tx_hold_r <= 1'b0;
         tx_empty_flag_r <= ~(wr & hit_txhold) & ~tx_hold_r &
                            ~TX_SHIFT_BUSY & ~TX_SHIFT_LOAD;
         tx_cnt_zero_d_r <= TX_CNT_ZERO;
         if (tx_cnt_reach)
            tx_dma_end_flag_r <= 1'b1;
         else if (TX_CNT_WR)
            tx_dma_end_flag_r <= 1'b0;
         tx_buffers_empty_flag_r <= TX_CNT_ZERO & TX_NCNT_ZERO;
      end
   end

   // Receive side flags and holding registers
   wire                      rx_cnt_reach = RX_CNT_ZERO & ~rx_cnt_zero_d_r;
   wire                      rx_rd = rd & hit_rxhold;
   always @(posedge CLK)
   begin
      if (RST)
      begin
         rx_word_r              <= `SSSIR_WORD_RST;
         rx_sync_word_r         <= `SSSIR_HALF_RST;
         rx_ready_flag_r        <= 1'b0;
         rx_overrun_flag_r      <= 1'b0;
         rx_dma_end_flag_r      <= 1'b0;
         rx_buffers_full_flag_r <= 1'b0;
         rx_cnt_zero_d_r        <= 1'b0;
      end
      else
      begin
         if (RX_WORD_LOAD)
            rx_word_r <= RX_WORD_IN & len_mask;
         if (RX_SYNC_LOAD)
            rx_sync_word_r <= RX_SYNC_IN;
         if (RX_WORD_LOAD)
            rx_ready_flag_r <= 1'b1;
         else if (rx_rd)
            rx_ready_flag_r <= 1'b0;
         // Word landing on an unread one; a read in the same cycle saves it
         if (RX_WORD_LOAD & rx_ready_flag_r & ~rx_rd)
            rx_overrun_flag_r <= 1'b1;
         else if (sr_read)
            rx_overrun_flag_r <= 1'b0;
         rx_cnt_zero_d_r <= RX_CNT_ZERO;
         if (rx_cnt_reach)
            rx_dma_end_flag_r <= 1'b1;
         else if (RX_CNT_WR)
            rx_dma_end_flag_r <= 1'b0;
         rx_buffers_full_flag_r <= RX_CNT_ZERO & RX_NCNT_ZERO;
      end
   end

   // Read-to-clear event flags; a new event beats the clearing read
   wire                      hit_a = RX_WORD_LOAD & (RX_WORD_IN[15:0] == cmp_a_r);
   wire                      hit_b = RX_WORD_LOAD & (RX_WORD_IN[15:0] == cmp_b_r);
   always @(posedge CLK)
   begin
      if (RST)
      begin
         compare_a_flag_r <= 1'b0;
         compare_b_flag_r <= 1'b0;
         tx_sync_flag_r   <= 1'b0;
         rx_sync_flag_r   <= 1'b0;
         irq_r            <= 1'b0;
      end
      else
      begin
         compare_a_flag_r <= hit_a | (compare_a_flag_r & ~sr_read);
         compare_b_flag_r <= hit_b | (compare_b_flag_r & ~sr_read);
         tx_sync_flag_r   <= tx_sync_evt | (tx_sync_flag_r & ~sr_read);
         rx_sync_flag_r   <= RX_SYNC_EVT | (rx_sync_flag_r & ~sr_read);
         irq_r            <= |(flags & mask_r);
      end
   end

   assign WB_DAT_O      = dat_r;
   assign WB_ACK_O      = ack_r;
   assign IRQ           = irq_r;
   assign TX_WORD       = tx_word_r;
   assign TX_WORD_VALID = tx_hold_r;
   assign TD_SYNC_BIT   = td_bit_r;
   assign TD_SYNC_OE    = td_oe_r;

endmodule // sssir_top

// File: testbench/sssir_top_sva.sv
// Checker of the register bus answer, holding handshake and sync output
`include "sssir_defines.vh"

module sssir_top_sva (
   input wire                    CLK,
   input wire                    RST,
   input wire                    WB_CYC_I,
   input wire                    WB_STB_I,
   input wire                    WB_WE_I,
   input wire [`SSSIR_ADR_W-1:0] WB_ADR_I,
   input wire [31:0]             WB_DAT_O,
   input wire                    WB_ACK_O,
   input wire                    TX_WORD_VALID,
   input wire                    TX_SHIFT_LOAD,
   input wire                    TX_CNT_ZERO,
   input wire                    TX_NCNT_ZERO,
   input wire                    RX_CNT_ZERO,
   input wire                    RX_NCNT_ZERO,
   input wire                    TX_EN_STAT,
   input wire                    RX_EN_STAT,
   input wire                    TF_PIN,
   input wire                    TD_SYNC_OE
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   wire take  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire rd_st = take & ~WB_WE_I & (WB_ADR_I == `SSSIR_OFF_STATUS);
   wire wr_tx = take & WB_WE_I & (WB_ADR_I == `SSSIR_OFF_TXHOLD);
   wire bufe  = TX_CNT_ZERO & TX_NCNT_ZERO;
   wire bfull = RX_CNT_ZERO & RX_NCNT_ZERO;

   ack_once_a: assert property (take |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("Bus answer was not one single pulse");
   txv_set_a: assert property (wr_tx |=> TX_WORD_VALID)
      else $error("Holding word not flagged after write");
   txv_hold_a: assert property (
      TX_WORD_VALID && !TX_SHIFT_LOAD |=> TX_WORD_VALID)
      else $error("Holding word lost before shifter load");
   txv_drop_a: assert property (
      TX_SHIFT_LOAD && TX_WORD_VALID && !wr_tx |=> !TX_WORD_VALID)
      else $error("Holding still full after shifter load");
   en_bits_a: assert property (
      rd_st && $stable({RX_EN_STAT, TX_EN_STAT})
      |=> WB_DAT_O[17:16] == $past({RX_EN_STAT, TX_EN_STAT}))
      else $error("Enable status bits wrong in status read");
   tx_bufe_a: assert property (
      rd_st && $stable(bufe) && !$past(RST) |=> WB_DAT_O[3] == $past(bufe))
      else $error("Transmit buffers empty flag wrong");
   rx_bfull_a: assert property (
      rd_st && $stable(bfull) && !$past(RST)
      |=> WB_DAT_O[7] == $past(bfull))
      else $error("Receive buffers full flag wrong");
   // Eight cycles covers the three-flop sense delay plus the output flop
   oe_idle_a: assert property (!TF_PIN [*8] |-> !TD_SYNC_OE)
      else $error("Sync data driven outside frame sync");
endmodule // sssir_top_sva

bind sssir_top sssir_top_sva chk_u (
   .CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .TX_WORD_VALID(TX_WORD_VALID),
   .TX_SHIFT_LOAD(TX_SHIFT_LOAD), .TX_CNT_ZERO(TX_CNT_ZERO),
   .TX_NCNT_ZERO(TX_NCNT_ZERO), .RX_CNT_ZERO(RX_CNT_ZERO),
   .RX_NCNT_ZERO(RX_NCNT_ZERO), .TX_EN_STAT(TX_EN_STAT),
   .RX_EN_STAT(RX_EN_STAT), .TF_PIN(TF_PIN), .TD_SYNC_OE(TD_SYNC_OE)
);

// File: testbench/sssir_peer.sv
// Partner model: transmit shifter and frame sync link of the serial peer
module sssir_peer (
   input  wire        clk,
   input  wire        rst,
   input  wire [3:0]  delay,
   input  wire        tx_valid,
   input  wire        td_bit,
   output logic       tx_load,
   output wire        tx_busy,
   output logic       tf,
   output logic       tk,
   output logic [7:0] samp
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] wait_r;
   logic [4:0] busy_r;

   initial
   begin
      tx_load = 1'b0;
      busy_r = 5'h00;
      tf = 1'b0;
      tk = 1'b0;
      samp = 8'h00;
   end

   // Shifter takes the word after a chosen delay, then sends for 16 cycles
   always @(posedge clk)
   begin
      tx_load <= 1'b0;
      if (rst)
      begin
         wait_r <= 4'h0;
         busy_r <= 5'h00;
      end
      else if (busy_r != 5'h00)
         busy_r <= busy_r - 5'h01;
      else if (tx_valid && wait_r == delay)
      begin
         tx_load <= 1'b1;
         busy_r <= 5'h10;
         wait_r <= 4'h0;
      end
      else if (tx_valid)
         wait_r <= wait_r + 4'h1;
   end
   assign tx_busy = (busy_r != 5'h00);

   // Link clock only runs inside a frame; data sampled 300 ns after a rise
   task automatic frame;
      #37;
      tf = 1'b1;
      #400;
      for (int i = 0; i < 8; i++)
      begin
         tk = 1'b1;
         #300;
         samp[i] = td_bit;
         #100;
         tk = 1'b0;
         #400;
      end
      #300;
      tf = 1'b0;
   endtask
endmodule // sssir_peer

// File: testbench/sssir_top_tb.sv
// Self-checking bench of the serial status and interrupt register block
`include "sssir_defines.vh"

module sssir_top_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk, rst, cyc, stb, we, ack, irq, txl, txb, txv;
   logic        rxl, rsl, rse, txz, txnz, txcw, rxz, rxnz, rxcw;
   logic        tx_enabled_status, rx_enabled_status, tf, tk, td, oe, stop;
   logic [7:0]  adr, samp;
   logic [3:0]  dly;
   logic [11:0] m;
   logic [15:0] rsi, ca, sw;
   logic [31:0] wdat, rx_word, rxd, txw, q, d, r;
   int          mismatches, n_tests;

   sssir_top dut_u (
      .CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
      .WB_DAT_O(rx_word), .WB_ACK_O(ack), .IRQ(irq), .TX_WORD(txw),
      .TX_WORD_VALID(txv), .TX_SHIFT_LOAD(txl), .TX_SHIFT_BUSY(txb),
      .RX_WORD_IN(rxd), .RX_WORD_LOAD(rxl), .RX_SYNC_IN(rsi),
      .RX_SYNC_LOAD(rsl), .RX_SYNC_EVT(rse), .TX_CNT_ZERO(txz),
      .TX_NCNT_ZERO(txnz), .TX_CNT_WR(txcw), .RX_CNT_ZERO(rxz),
      .RX_NCNT_ZERO(rxnz), .RX_CNT_WR(rxcw), .TX_EN_STAT(tx_enabled_status),
      .RX_EN_STAT(rx_enabled_status), .TF_PIN(tf), .TK_PIN(tk), .TD_SYNC_BIT(td),
      .TD_SYNC_OE(oe)
   );

   sssir_peer peer_u (
      .clk(clk), .rst(rst), .delay(dly), .tx_valid(txv), .td_bit(td),
      .tx_load(txl), .tx_busy(txb), .tf(tf), .tk(tk), .samp(samp)
   );

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [31:0] st(input logic [11:0] f);
      return {14'h0, rx_enabled_status, tx_enabled_status, 4'h0, f};
   endfunction

   // Classic single cycle; read data lands in q at the acknowledging edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] v = 32'h0);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      @(posedge clk);
      while (ack !== 1'b1 && n < 40)
      begin
         n++;
         @(posedge clk);
      end
      if (n == 40)
      begin
         mismatches++;
         stop = 1'b1;
      end
      q = rx_word;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic sck(input logic [11:0] f);
      wb(1'b0, `SSSIR_OFF_STATUS);
      chk(q, st(f));
   endtask

   task automatic rxw(input logic [31:0] w);
      rxd <= w;
      rxl <= 1'b1;
      @(posedge clk);
      rxl <= 1'b0;
      @(posedge clk);
   endtask

   initial
   begin
      for (int i = 0; i < 20000 && stop !== 1'b1; i++)
         @(posedge clk);
      if (stop !== 1'b1)
         mismatches++;
      end_sim();
   end

   initial
   begin
      {cyc, stb, we, rxl, rsl, rse, txz, txnz, txcw, rxz, rxnz, rxcw} = 12'h0;
      {adr, wdat, rxd, rsi, dly, stop, mismatches, n_tests} = 0;
      rst = 1'b1;
      void'($urandom(32'h81E9));
      r = $urandom;
      tx_enabled_status = r[0];
      rx_enabled_status = r[1];
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      sck(12'h003);
      wb(1'b0, `SSSIR_OFF_IRQMASK);
      chk(q, 32'h0);
      m = 12'h000;
      repeat (6)
      begin
         r = $urandom;
         wb(1'b1, `SSSIR_OFF_IRQSET, r);
         m = m | r[11:0];
         wb(1'b0, `SSSIR_OFF_IRQMASK);
         chk(q, {20'h0, m});
         r = $urandom;
         wb(1'b1, `SSSIR_OFF_IRQCLR, r);
         m = m & ~r[11:0];
         wb(1'b0, `SSSIR_OFF_IRQMASK);
         chk(q, {20'h0, m});
      end
      for (int i = 0; i < 3; i++)
      begin
         r = (i == 0) ? 32'hFFF : 32'h2;
         wb(1'b1, i == 1 ? `SSSIR_OFF_IRQSET : `SSSIR_OFF_IRQCLR, r);
         @(posedge clk);
         chk({31'h0, irq}, i == 1);
      end
      dly <= 4'h6;
      d = $urandom;
      wb(1'b1, `SSSIR_OFF_TXHOLD, d);
      chk(txw, d);
      sck(12'h000);
      for (int n = 0; n < 30 && txv !== 1'b0; n++)
         @(posedge clk);
      chk({31'h0, txv}, 32'h0);
      sck(12'h001);
      repeat (24) @(posedge clk);
      sck(12'h003);
      dly <= 4'h2;
      wb(1'b1, `SSSIR_OFF_CONFIG, 32'h7);
      d = $urandom;
      wb(1'b1, `SSSIR_OFF_TXHOLD, d);
      chk(txw, d & 32'hFF);
      wb(1'b1, `SSSIR_OFF_CONFIG, 32'h1F);
      r = $urandom;
      ca = r[15:0];
      wb(1'b1, `SSSIR_OFF_CMPA, {16'h0, ca});
      wb(1'b1, `SSSIR_OFF_CMPB, {16'h0, ~ca});
      wb(1'b0, `SSSIR_OFF_CMPB);
      chk(q, {16'h0, ~ca});
      sck(12'h001);
      repeat (6) @(posedge clk);
      d = {r[31:16], ca};
      rxw(d);
      sck(12'h113);
      sck(12'h013);
      wb(1'b0, `SSSIR_OFF_RXHOLD);
      chk(q, d);
      sck(12'h003);
      rxw({r[31:16], ~ca});
      d = {r[31:16], ca ^ 16'h0F0F};
      rxw(d);
      sck(12'h233);
      sck(12'h013);
      wb(1'b0, `SSSIR_OFF_RXHOLD);
      chk(q, d);
      {txz, txnz, rxz, rxnz} <= 4'hF;
      repeat (2) @(posedge clk);
      sck(12'h0CF);
      {txnz, rxnz, txcw, rxcw} <= 4'h3;
      @(posedge clk);
      {txcw, rxcw} <= 2'h0;
      repeat (2) @(posedge clk);
      sck(12'h003);
      {txz, rxz} <= 2'h0;
      sw = r[31:16];
      wb(1'b1, `SSSIR_OFF_TXSYNC, {16'h0, sw});
      wb(1'b0, `SSSIR_OFF_TXSYNC);
      chk(q, {16'h0, sw});
      {rsi, rsl, rse} <= {~sw, 2'h3};
      @(posedge clk);
      {rsl, rse} <= 2'h0;
      wb(1'b0, `SSSIR_OFF_RXSYNC);
      chk(q, {16'h0, ~sw});
      sck(12'h803);
      for (int e = 0; e < 2; e++)
      begin
         wb(1'b1, `SSSIR_OFF_CONFIG, e ? 32'h31F : 32'h21F);
         fork
            peer_u.frame();
            begin
               repeat (30) @(posedge clk);
               sck(e ? 12'h003 : 12'h403);
               chk({31'h0, oe}, 32'h1);
            end
         join
         repeat (10) @(posedge clk);
         sck(e ? 12'h403 : 12'h003);
         chk({31'h0, oe}, 32'h0);
         chk({24'h0, samp}, {24'h0, sw[7:0]});
      end
      stop = 1'b1;
   end
endmodule // sssir_top_tb
